//--- dv/lcdc_host_model.sv
// lcdc_host_model: 8-bit host that writes command codes and parameter bytes to the decoder
// assumes: CORE_CLK from the bench; callers sequence the bytes, this module only times them
`timescale 1ns/1ps
module lcdc_host_model
	import lcdc_pkg::*;
(
	input  wire logic       CORE_CLK,      // system clock
	output logic            WR_STROBE,     // one cycle per byte while held
	output logic            CMD_DATA_SEL,  // high for command, low for parameter
	output logic [7:0]      WR_DATA        // byte on the bus
);
	// bus parked with strobe low from time zero
	initial begin
		WR_STROBE    = 1'b0;
		CMD_DATA_SEL = 1'b0;
		WR_DATA      = 8'hA5;
	end

	// one byte; strobe stays high across back-to-back calls, so each rising edge is a new write
	task automatic put(input logic sel, input logic [7:0] d);
		@(negedge CORE_CLK);
		WR_STROBE    = 1'b1;
		CMD_DATA_SEL = sel;
		WR_DATA      = d;
	endtask

	// released bus shows the inverse of the last byte, so a stale value cannot pass for a write
	task automatic rest();
		@(negedge CORE_CLK);
		WR_STROBE    = 1'b0;
		CMD_DATA_SEL = ~CMD_DATA_SEL;
		WR_DATA      = ~WR_DATA;
	endtask
endmodule

//--- dv/tb.sv
// tb: self-checking bench for the command decoder, writes through the host model and watches CFG
// assumes: design files compiled first; lcdc_params.svh on the include path
`timescale 1ns/1ps
module tb;
	import lcdc_pkg::*;
	logic        core_clk;      // 100 MHz
	logic        nrst;          // active-low reset
	logic        wr_strobe;     // from host model
	logic        cmd_data_sel;  // from host model
	logic [7:0]  wr_data;       // from host model
	lcdc_cfg_s   cfg;           // decoded configuration
	lcdc_cmd_e   active_cmd;    // command taking parameters
	logic [3:0]  param_index;   // parameters taken
	lcdc_cfg_s   e;             // expected configuration
	int          fails;         // mismatches
	int          total_checks;  // comparisons made

	lcdc_host_model i_lcdc_host_model (.CORE_CLK(core_clk), .WR_STROBE(wr_strobe),
		.CMD_DATA_SEL(cmd_data_sel), .WR_DATA(wr_data));
	lcdc_cmd_decoder i_lcdc_cmd_decoder (.CORE_CLK(core_clk), .NRST(nrst), .WR_STROBE(wr_strobe),
		.CMD_DATA_SEL(cmd_data_sel), .WR_DATA(wr_data), .CFG(cfg), .ACTIVE_CMD(active_cmd),
		.PARAM_INDEX(param_index));

	// clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// one comparison; case inequality so an unknown never matches
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// command byte then its parameters, back to back; no release at the end
	task automatic send(input logic [7:0] c, input logic [7:0] p[$]);
		i_lcdc_host_model.put(1'b1, c);
		foreach (p[i]) i_lcdc_host_model.put(1'b0, p[i]);
	endtask

	// release the bus, then the last byte has landed
	task automatic idle();
		i_lcdc_host_model.rest();
	endtask

	// every field against the expected copy
	task automatic check_cfg();
		chk("font_source_select", 16'(cfg.font_source_select), 16'(e.font_source_select));
		chk("char_line_count", 16'(cfg.char_line_count), 16'(e.char_line_count));
		chk("panel_drive_select", 16'(cfg.panel_drive_select), 16'(e.panel_drive_select));
		chk("top_line_compensation", 16'(cfg.top_line_compensation), 16'(e.top_line_compensation));
		chk("char_width", 16'(cfg.char_width), 16'(e.char_width));
		chk("ac_drive_frames", 16'(cfg.ac_drive_frames), 16'(e.ac_drive_frames));
		chk("char_height", 16'(cfg.char_height), 16'(e.char_height));
		chk("bytes_per_line", 16'(cfg.bytes_per_line), 16'(e.bytes_per_line));
		chk("total_line_length", 16'(cfg.total_line_length), 16'(e.total_line_length));
		chk("lines_per_frame", 16'(cfg.lines_per_frame), 16'(e.lines_per_frame));
		chk("virtual_line_pitch", cfg.virtual_line_pitch, e.virtual_line_pitch);
		chk("block1_start", cfg.block1_start, e.block1_start);
		chk("block1_line_count", 16'(cfg.block1_line_count), 16'(e.block1_line_count));
		chk("block2_start", cfg.block2_start, e.block2_start);
		chk("block2_line_count", 16'(cfg.block2_line_count), 16'(e.block2_line_count));
		chk("block3_start", cfg.block3_start, e.block3_start);
		chk("block4_start", cfg.block4_start, e.block4_start);
		chk("pixel_shift", 16'(cfg.pixel_shift), 16'(e.pixel_shift));
		chk("layer_combine_method", 16'(cfg.layer_combine_method), 16'(e.layer_combine_method));
		chk("first_block_text", 16'(cfg.first_block_text_select), 16'(e.first_block_text_select));
		chk("third_block_text", 16'(cfg.third_block_text_select), 16'(e.third_block_text_select));
	endtask

	// state of the command sequencer
	task automatic check_seq(input lcdc_cmd_e c, input logic [3:0] n);
		chk("active_cmd", 16'(active_cmd), 16'(c));
		chk("param_index", 16'(param_index), 16'(n));
	endtask

	// verdict, reached from the tests and from the watchdog
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// the whole run is under a hundred cycles; 20 us leaves ample margin
	initial begin
		#20000;
		fails++;
		summarize();
	end

	// main sequence
	initial begin
		fails = 0;
		total_checks = 0;
		e = '0;
		nrst = 1'b0;
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		check_cfg();
		check_seq(LCDC_IDLE, 4'h0);
		// full setup list plus one extra byte that must be dropped
		send(8'h40, {8'h38, 8'h87, 8'h07, 8'h3F, 8'h49, 8'h7F, 8'h80, 8'h00, 8'hFF});
		idle();
		e.panel_drive_select = 1'b1;
		e.top_line_compensation = 1'b1;
		e.char_width = 4'h7;
		e.ac_drive_frames = 1'b1;
		e.char_height = 4'h7;
		e.bytes_per_line = 8'h3F;
		e.total_line_length = 8'h49;
		e.lines_per_frame = 8'h7F;
		e.virtual_line_pitch = 16'h0080;
		check_cfg();
		check_seq(LCDC_SETUP, 4'h8);
		// partial setup with the other bit values; later registers keep their contents
		send(8'h40, {8'hD7, 8'h0E});
		idle();
		e.font_source_select = 1'b1;
		e.char_line_count = 1'b1;
		e.panel_drive_select = 1'b0;
		e.top_line_compensation = 1'b0;
		e.char_width = 4'hE;
		e.ac_drive_frames = 1'b0;
		check_cfg();
		check_seq(LCDC_SETUP, 4'h2);
		// screen blocks, full list
		send(8'h44, {8'h00, 8'h00, 8'h40, 8'h00, 8'h10, 8'h40, 8'h00, 8'h04, 8'h00, 8'h30});
		idle();
		e.block1_line_count = 8'h40;
		e.block2_start = 16'h1000;
		e.block2_line_count = 8'h40;
		e.block3_start = 16'h0400;
		e.block4_start = 16'h3000;
		check_cfg();
		check_seq(LCDC_BLOCKS, 4'hA);
		// blocks cut short by a shift command; its second byte is dropped
		send(8'h44, {8'hAA, 8'hBB});
		send(8'h5A, {8'hFD, 8'h07});
		idle();
		e.block1_start = 16'hBBAA;
		e.pixel_shift = 3'h5;
		check_cfg();
		check_seq(LCDC_HSHIFT, 4'h1);
		// every combine method and both text selects
		for (int i = 0; i < 4; i++) begin
			send(8'h5B, {8'(i * 5)});
			idle();
			e.layer_combine_method = 2'(i);
			e.first_block_text_select = 1'((i * 5) >> 2);
			e.third_block_text_select = 1'((i * 5) >> 3);
			check_cfg();
			check_seq(LCDC_OVERLAY, 4'h1);
		end
		// command outside this block: its parameters change nothing
		send(8'h42, {8'h20, 8'h45});
		idle();
		check_cfg();
		check_seq(LCDC_IDLE, 4'h0);
		// reset in mid-run clears everything
		@(negedge core_clk);
		nrst = 1'b0;
		@(negedge core_clk);
		e = '0;
		check_cfg();
		check_seq(LCDC_IDLE, 4'h0);
		nrst = 1'b1;
		// first command after release must land normally
		send(8'h5B, {8'h01});
		idle();
		e.layer_combine_method = 2'h1;
		check_cfg();
		check_seq(LCDC_OVERLAY, 4'h1);
		summarize();
	end
endmodule

//--- hdl/lcdc_cmd_decoder.sv
// lcdc_cmd_decoder: indirect command/parameter port of the LCD controller and its configuration registers
// assumes: host write strobe is one CORE_CLK cycle per byte and synchronous to CORE_CLK;
// the display timing logic reads CFG and treats it as static between commands
`timescale 1ns/1ps
`include "lcdc_params.svh"

module lcdc_cmd_decoder
	import lcdc_pkg::*;
(
	input  wire logic       CORE_CLK,      // system clock, 100 MHz
	input  wire logic       NRST,          // asynchronous reset, active low
	input  wire logic       WR_STROBE,     // one-cycle host write
	input  wire logic       CMD_DATA_SEL,  // high: command code, low: parameter byte
	input  wire logic [7:0] WR_DATA,       // byte written by the host
	output lcdc_cfg_s       CFG,           // decoded configuration
	output lcdc_cmd_e       ACTIVE_CMD,    // command now taking parameters
	output logic [3:0]      PARAM_INDEX    // number of parameters taken so far
);

	lcdc_state_s st;       // registered state
	lcdc_state_s next_st;  // next state

	logic       cmd_wr;     // command code written
	logic       par_wr;     // parameter byte written
	logic       tgt_valid;  // current parameter has a home
	logic [4:0] tgt_ofs;    // register that the parameter lands in
	logic [7:0] tgt_mask;   // writable bits of that register

	// map a command and parameter number to a register offset
	function automatic logic [5:0] param_target(input lcdc_cmd_e cmd, input logic [3:0] idx);
		logic [5:0] r;
		r = 6'h00;
		unique case (cmd)
			LCDC_IDLE: begin
				r = 6'h00;  // no command: parameter is dropped
			end
			LCDC_SETUP: begin
				if (idx < `LCDC_SETUP_PARAMS) begin
					r = {1'b1, `LCDC_OFS_SYSTEM_CONFIG + {1'b0, idx}};
				end
			end
			LCDC_BLOCKS: begin
				if (idx < `LCDC_BLOCK_PARAMS) begin
					r = {1'b1, `LCDC_OFS_BLOCK1_LOW + {1'b0, idx}};
				end
			end
			LCDC_HSHIFT: begin
				if (idx < `LCDC_ONE_PARAM) begin
					r = {1'b1, `LCDC_OFS_PIXEL_SHIFT};
				end
			end
			LCDC_OVERLAY: begin
				if (idx < `LCDC_ONE_PARAM) begin
					r = {1'b1, `LCDC_OFS_LAYER_OVERLAY};
				end
			end
			default: begin
				r = 6'h00;  // illegal code: drop the byte
			end
		endcase
		return r;
	endfunction

	// writable bits per register; undefined bits stay zero so they read back clean
	function automatic logic [7:0] reg_mask(input logic [4:0] ofs);
		logic [7:0] m;
		m = `LCDC_MASK_FULL;
		unique case (ofs)
			`LCDC_OFS_SYSTEM_CONFIG: m = `LCDC_MASK_SYSTEM_CONFIG;
			`LCDC_OFS_CHAR_WIDTH:    m = `LCDC_MASK_CHAR_WIDTH;
			`LCDC_OFS_CHAR_HEIGHT:   m = `LCDC_MASK_CHAR_HEIGHT;
			`LCDC_OFS_LAYER_OVERLAY: m = `LCDC_MASK_LAYER_OVERLAY;
			`LCDC_OFS_PIXEL_SHIFT:   m = `LCDC_MASK_PIXEL_SHIFT;
			default:                 m = `LCDC_MASK_FULL;
		endcase
		return m;
	endfunction

	// decode the host port; the select line alone tells command from parameter
	assign cmd_wr = WR_STROBE & CMD_DATA_SEL;
	assign par_wr = WR_STROBE & ~CMD_DATA_SEL;
	assign {tgt_valid, tgt_ofs} = param_target(st.cmd, st.idx);
	assign tgt_mask = reg_mask(tgt_ofs);

	// next state: command restarts the sequence, each parameter with a target takes the next slot
	always_comb begin
		next_st = st;
		if (cmd_wr) begin
			next_st.idx = 4'h0;
			unique case (WR_DATA)
				`LCDC_CMD_SYSTEM_SETUP:  next_st.cmd = LCDC_SETUP;
				`LCDC_CMD_BLOCK_SETUP:   next_st.cmd = LCDC_BLOCKS;
				`LCDC_CMD_HSHIFT:        next_st.cmd = LCDC_HSHIFT;
				`LCDC_CMD_LAYER_COMBINE: next_st.cmd = LCDC_OVERLAY;
				// memory write and the rest belong to other blocks; their data bytes are ignored here
				default:                 next_st.cmd = LCDC_IDLE;
			endcase
		end else if (par_wr && tgt_valid) begin
			// a short list leaves later registers as they were
			next_st.regs[tgt_ofs] = WR_DATA & tgt_mask;
			next_st.idx = st.idx + 4'h1;
		end
	end

	// state register; every register clears to zero, nothing else is trustworthy before setup
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			st.cmd  <= LCDC_IDLE;
			st.idx  <= 4'h0;
			st.regs <= '0;
		end else begin
			st <= next_st;
		end
	end

	// configuration fields straight from the register flops
	assign CFG.font_source_select    = st.regs[`LCDC_OFS_SYSTEM_CONFIG][`LCDC_BIT_FONT_SOURCE];
	assign CFG.char_line_count       = st.regs[`LCDC_OFS_SYSTEM_CONFIG][`LCDC_BIT_CHAR_LINES];
	assign CFG.panel_drive_select    = st.regs[`LCDC_OFS_SYSTEM_CONFIG][`LCDC_BIT_PANEL_DRIVE];
	assign CFG.top_line_compensation = st.regs[`LCDC_OFS_SYSTEM_CONFIG][`LCDC_BIT_TOP_LINE_COMP];
	assign CFG.char_width            = st.regs[`LCDC_OFS_CHAR_WIDTH][3:0];
	assign CFG.ac_drive_frames       = st.regs[`LCDC_OFS_CHAR_WIDTH][`LCDC_BIT_AC_DRIVE];
	assign CFG.char_height           = st.regs[`LCDC_OFS_CHAR_HEIGHT][3:0];
	assign CFG.bytes_per_line        = st.regs[`LCDC_OFS_BYTES_PER_LINE];
	assign CFG.total_line_length     = st.regs[`LCDC_OFS_TOTAL_LINE];
	assign CFG.lines_per_frame       = st.regs[`LCDC_OFS_LINES_FRAME];
	assign CFG.virtual_line_pitch    = {st.regs[`LCDC_OFS_PITCH_HIGH], st.regs[`LCDC_OFS_PITCH_LOW]};
	assign CFG.block1_start          = {st.regs[`LCDC_OFS_BLOCK1_HIGH], st.regs[`LCDC_OFS_BLOCK1_LOW]};
	assign CFG.block1_line_count     = st.regs[`LCDC_OFS_BLOCK1_LINES];
	assign CFG.block2_start          = {st.regs[`LCDC_OFS_BLOCK2_HIGH], st.regs[`LCDC_OFS_BLOCK2_LOW]};
	assign CFG.block2_line_count     = st.regs[`LCDC_OFS_BLOCK2_LINES];
	assign CFG.block3_start          = {st.regs[`LCDC_OFS_BLOCK3_HIGH], st.regs[`LCDC_OFS_BLOCK3_LOW]};
	assign CFG.block4_start          = {st.regs[`LCDC_OFS_BLOCK4_HIGH], st.regs[`LCDC_OFS_BLOCK4_LOW]};
	assign CFG.layer_combine_method  = st.regs[`LCDC_OFS_LAYER_OVERLAY][1:0];
	assign CFG.first_block_text_select = st.regs[`LCDC_OFS_LAYER_OVERLAY][`LCDC_BIT_BLOCK1_TEXT];
	assign CFG.third_block_text_select = st.regs[`LCDC_OFS_LAYER_OVERLAY][`LCDC_BIT_BLOCK3_TEXT];
	assign CFG.pixel_shift           = st.regs[`LCDC_OFS_PIXEL_SHIFT][2:0];

	// decoder status for the rest of the controller
	assign ACTIVE_CMD  = st.cmd;
	assign PARAM_INDEX = st.idx;

	// a system setup command write restarts numbering and picks the setup command
	chk_cmd_restart: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		cmd_wr && WR_DATA == `LCDC_CMD_SYSTEM_SETUP |=> st.idx == 4'h0 && st.cmd == LCDC_SETUP)
		else $error("command write did not restart parameter index");

	// first setup byte lands in register 0 with only its defined bits
	chk_setup_first: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h0
		|=> CFG.font_source_select == $past(WR_DATA[0]) && CFG.panel_drive_select == $past(WR_DATA[3])
		&& CFG.char_line_count == $past(WR_DATA[2]) && CFG.top_line_compensation == $past(WR_DATA[5]))
		else $error("setup byte one not stored in system config");

	// second byte carries width and drive mode
	chk_setup_width: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h1
		|=> CFG.char_width == $past(WR_DATA[3:0]) && CFG.ac_drive_frames == $past(WR_DATA[7]))
		else $error("setup byte two not stored in width register");

	// full setup sequence: the 8 bytes fill the pitch last, high byte from P8
	chk_setup_pitch: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h6 ##1 par_wr && !cmd_wr
		|=> CFG.virtual_line_pitch == {$past(WR_DATA), $past(WR_DATA, 2)})
		else $error("virtual pitch bytes misplaced");

	// block setup P5 is the high byte of the second block start
	chk_block2_high: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h4 |=> CFG.block2_start[15:8] == $past(WR_DATA))
		else $error("second block high byte misplaced");

	// the tenth block byte finishes the fourth block start
	chk_block4_high: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h9 |=> CFG.block4_start[15:8] == $past(WR_DATA))
		else $error("fourth block high byte misplaced");

	// shift register keeps three bits only
	chk_shift_load: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_HSHIFT && st.idx == 4'h0
		|=> CFG.pixel_shift == $past(WR_DATA[2:0]) && st.regs[`LCDC_OFS_PIXEL_SHIFT][7:3] == 5'h00)
		else $error("pixel shift not loaded");

	// overlay byte sets method and both text selects
	chk_overlay_load: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_OVERLAY && st.idx == 4'h0
		|=> CFG.layer_combine_method == $past(WR_DATA[1:0]) && CFG.first_block_text_select == $past(WR_DATA[2])
		&& CFG.third_block_text_select == $past(WR_DATA[3]))
		else $error("overlay byte not loaded");

	// parameters past the list, or without a known command, change nothing
	chk_extra_dropped: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && !tgt_valid |=> $stable(st.regs) && $stable(st.idx))
		else $error("surplus parameter altered registers");

	// with the select high the byte is never stored as a parameter
	chk_select_cmd: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		cmd_wr |=> $stable(st.regs))
		else $error("command byte written into a register");

	// per-field landing checks; each names the parameter slot it expects

	// setup P1 bit 2: character line mode
	chk_char_lines: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h0
		|=> CFG.char_line_count == $past(WR_DATA[2]))
		else $error("character line mode not stored");

	// setup P1 bit 3: panel drive
	chk_panel_drive: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h0
		|=> CFG.panel_drive_select == $past(WR_DATA[3]))
		else $error("panel drive select not stored");

	// setup P1 bit 5: top-line compensation
	chk_top_line: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h0
		|=> CFG.top_line_compensation == $past(WR_DATA[5]))
		else $error("top-line compensation not stored");

	// setup P2 bit 7: AC drive frames
	chk_ac_drive: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h1
		|=> CFG.ac_drive_frames == $past(WR_DATA[7]))
		else $error("AC drive frames not stored");

	// setup P3: character height nibble
	chk_setup_height: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h2
		|=> CFG.char_height == $past(WR_DATA[3:0]))
		else $error("character height not stored");

	// setup P4: bytes per line
	chk_bytes_line: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h3
		|=> CFG.bytes_per_line == $past(WR_DATA))
		else $error("bytes per line not stored");

	// setup P5: total line length
	chk_total_line: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h4
		|=> CFG.total_line_length == $past(WR_DATA))
		else $error("total line length not stored");

	// setup P6: lines per frame
	chk_lines_frame: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h5
		|=> CFG.lines_per_frame == $past(WR_DATA))
		else $error("lines per frame not stored");

	// setup P7: low byte of the pitch
	chk_pitch_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_SETUP && st.idx == 4'h6
		|=> CFG.virtual_line_pitch[7:0] == $past(WR_DATA))
		else $error("virtual pitch low byte misplaced");

	// block P1: first block start, low byte
	chk_block1_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h0
		|=> CFG.block1_start[7:0] == $past(WR_DATA))
		else $error("first block low byte misplaced");

	// block P2: first block start, high byte
	chk_block1_high: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h1
		|=> CFG.block1_start[15:8] == $past(WR_DATA))
		else $error("first block high byte misplaced");

	// block P3: first block line count
	chk_block1_lines: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h2
		|=> CFG.block1_line_count == $past(WR_DATA))
		else $error("first block line count misplaced");

	// block P4: second block start, low byte
	chk_block2_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h3
		|=> CFG.block2_start[7:0] == $past(WR_DATA))
		else $error("second block low byte misplaced");

	// block P6: second block line count
	chk_block2_lines: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h5
		|=> CFG.block2_line_count == $past(WR_DATA))
		else $error("second block line count misplaced");

	// block P7: third block start, low byte
	chk_block3_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h6
		|=> CFG.block3_start[7:0] == $past(WR_DATA))
		else $error("third block low byte misplaced");

	// block P8: third block start, high byte
	chk_block3_high: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h7
		|=> CFG.block3_start[15:8] == $past(WR_DATA))
		else $error("third block high byte misplaced");

	// block P9: fourth block start, low byte
	chk_block4_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_BLOCKS && st.idx == 4'h8
		|=> CFG.block4_start[7:0] == $past(WR_DATA))
		else $error("fourth block low byte misplaced");

	// overlay bit 2: first block text select
	chk_text_first: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_OVERLAY && st.idx == 4'h0
		|=> CFG.first_block_text_select == $past(WR_DATA[2]))
		else $error("first block text select not stored");

	// overlay bit 3: third block text select
	chk_text_third: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && st.cmd == LCDC_OVERLAY && st.idx == 4'h0
		|=> CFG.third_block_text_select == $past(WR_DATA[3]))
		else $error("third block text select not stored");

	// an accepted parameter moves the index by exactly one
	chk_index_step: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		par_wr && tgt_valid
		|=> st.idx == $past(st.idx) + 4'h1)
		else $error("parameter index did not advance by one");

	// block command restarts the sequence
	chk_block_cmd: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		cmd_wr && WR_DATA == `LCDC_CMD_BLOCK_SETUP
		|=> st.cmd == LCDC_BLOCKS && st.idx == 4'h0)
		else $error("block command not taken");

	// shift command restarts the sequence
	chk_shift_cmd: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		cmd_wr && WR_DATA == `LCDC_CMD_HSHIFT
		|=> st.cmd == LCDC_HSHIFT && st.idx == 4'h0)
		else $error("shift command not taken");

	// codes owned by other blocks leave the decoder idle
	chk_unknown_cmd: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		cmd_wr && !(WR_DATA inside {`LCDC_CMD_SYSTEM_SETUP, `LCDC_CMD_BLOCK_SETUP,
		`LCDC_CMD_HSHIFT, `LCDC_CMD_LAYER_COMBINE}) |=> st.cmd == LCDC_IDLE && st.idx == 4'h0)
		else $error("foreign command not dropped");

	// undefined bits of register 0 never hold a one
	chk_config_mask: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(st.regs[`LCDC_OFS_SYSTEM_CONFIG] & ~`LCDC_MASK_SYSTEM_CONFIG)
		== 8'h00)
		else $error("undefined system config bit stored");

	// bits 6-4 of the width register never hold a one
	chk_width_mask: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(st.regs[`LCDC_OFS_CHAR_WIDTH] & ~`LCDC_MASK_CHAR_WIDTH)
		== 8'h00)
		else $error("undefined width register bit stored");

endmodule

//--- hdl/lcdc_params.svh
// lcdc_params.svh: offsets, field positions, command codes and parameter counts of the command decoder
// assumes: included by bare name from the package and the decoder; definitions only
`ifndef LCDC_PARAMS_SVH
`define LCDC_PARAMS_SVH

// command codes, written with command_data_select high
`define LCDC_CMD_SYSTEM_SETUP   8'h40
`define LCDC_CMD_BLOCK_SETUP    8'h44
`define LCDC_CMD_HSHIFT         8'h5A
`define LCDC_CMD_LAYER_COMBINE  8'h5B

// parameter bytes each command consumes
`define LCDC_SETUP_PARAMS       4'h8
`define LCDC_BLOCK_PARAMS       4'hA
`define LCDC_ONE_PARAM          4'h1

// register file size and offsets
`define LCDC_NUM_REGS           28
`define LCDC_OFS_SYSTEM_CONFIG  5'h00
`define LCDC_OFS_CHAR_WIDTH     5'h01
`define LCDC_OFS_CHAR_HEIGHT    5'h02
`define LCDC_OFS_BYTES_PER_LINE 5'h03
`define LCDC_OFS_TOTAL_LINE     5'h04
`define LCDC_OFS_LINES_FRAME    5'h05
`define LCDC_OFS_PITCH_LOW      5'h06
`define LCDC_OFS_PITCH_HIGH     5'h07
`define LCDC_OFS_BLOCK1_LOW     5'h0B
`define LCDC_OFS_BLOCK1_HIGH    5'h0C
`define LCDC_OFS_BLOCK1_LINES   5'h0D
`define LCDC_OFS_BLOCK2_LOW     5'h0E
`define LCDC_OFS_BLOCK2_HIGH    5'h0F
`define LCDC_OFS_BLOCK2_LINES   5'h10
`define LCDC_OFS_BLOCK3_LOW     5'h11
`define LCDC_OFS_BLOCK3_HIGH    5'h12
`define LCDC_OFS_BLOCK4_LOW     5'h13
`define LCDC_OFS_BLOCK4_HIGH    5'h14
`define LCDC_OFS_LAYER_OVERLAY  5'h18
`define LCDC_OFS_PIXEL_SHIFT    5'h1B

// field positions
`define LCDC_BIT_FONT_SOURCE    0
`define LCDC_BIT_CHAR_LINES     2
`define LCDC_BIT_PANEL_DRIVE    3
`define LCDC_BIT_TOP_LINE_COMP  5
`define LCDC_BIT_AC_DRIVE       7
`define LCDC_BIT_BLOCK1_TEXT    2
`define LCDC_BIT_BLOCK3_TEXT    3

// writable bits of the narrow registers; all others read zero
`define LCDC_MASK_SYSTEM_CONFIG 8'h2D
`define LCDC_MASK_CHAR_WIDTH    8'h8F
`define LCDC_MASK_CHAR_HEIGHT   8'h0F
`define LCDC_MASK_LAYER_OVERLAY 8'h0F
`define LCDC_MASK_PIXEL_SHIFT   8'h07
`define LCDC_MASK_FULL          8'hFF

// reset value of every register
`define LCDC_REG_RESET          8'h00

`endif

//--- hdl/lcdc_pkg.sv
// lcdc_pkg: types shared by the command decoder and its users
// assumes: lcdc_params.svh on the include path
`include "lcdc_params.svh"
package lcdc_pkg;
	// command being served; gray codes along the usual order of setup
	typedef enum logic [2:0] {
		LCDC_IDLE    = 3'b000,
		LCDC_SETUP   = 3'b001,
		LCDC_BLOCKS  = 3'b011,
		LCDC_HSHIFT  = 3'b010,
		LCDC_OVERLAY = 3'b110
	} lcdc_cmd_e;

	// whole state of the decoder
	typedef struct packed {
		lcdc_cmd_e                       cmd;   // command whose parameters are expected
		logic [3:0]                      idx;   // next parameter number
		logic [`LCDC_NUM_REGS-1:0][7:0]  regs;  // configuration registers
	} lcdc_state_s;

	// decoded configuration toward the timing and layering logic
	typedef struct packed {
		logic        font_source_select;
		logic        char_line_count;
		logic        panel_drive_select;
		logic        top_line_compensation;
		logic [3:0]  char_width;
		logic        ac_drive_frames;
		logic [3:0]  char_height;
		logic [7:0]  bytes_per_line;
		logic [7:0]  total_line_length;
		logic [7:0]  lines_per_frame;
		logic [15:0] virtual_line_pitch;
		logic [15:0] block1_start;
		logic [7:0]  block1_line_count;
		logic [15:0] block2_start;
		logic [7:0]  block2_line_count;
		logic [15:0] block3_start;
		logic [15:0] block4_start;
		logic [1:0]  layer_combine_method;
		logic        first_block_text_select;
		logic        third_block_text_select;
		logic [2:0]  pixel_shift;
	} lcdc_cfg_s;
endpackage
